/* File: sim/pcv_testbench.sv */
// Testbench and frame buffer controller model for the pixel clock and video control block
module pcv_partner
   import pcv_pkg::*;
(
   input wire logic clock,
   input wire logic divided_load_clock_out,
   output pcv_pixel_t pixel_port_a,
   output pcv_pixel_t pixel_port_b,
   output logic pixel_load_strobe_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Ports idle blanked with sync released, both active low
   initial begin
      pixel_port_a = 28'h000_0001;
      pixel_port_b = 28'h000_0001;
      pixel_load_strobe_in = 1'b0;
   end
   // Presents one pixel pair in the next load slot and strobes it for one cycle
   task automatic send(input pcv_pixel_t a, input pcv_pixel_t b);
      a.blank_n = a.blank_n & a.sync_n;
      b.blank_n = b.blank_n & b.sync_n;
      do begin
         @(posedge clock);
         #1;
      end while (divided_load_clock_out !== 1'b1);
      pixel_port_a = a;
      pixel_port_b = b;
      pixel_load_strobe_in = 1'b1;
      @(posedge clock);
      #1;
      pixel_load_strobe_in = 1'b0;
   endtask
endmodule

module testbench
   import pcv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic lo = 1'b0;
   logic hi = 1'b0;
   logic two_to_one_mode = 1'b1;
   logic sync_decode_enable = 1'b1;
   logic video_shift_clock_in = 1'b1;
   logic q;
   logic divided_load_clock_out;
   logic gated_video_shift_clock;
   logic pipelined_sync_echo;
   logic pixel_load_strobe_in;
   pcv_pixel_t pixel_port_a;
   pcv_pixel_t pixel_port_b;
   pcv_video_t video_out;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   time t;
   pcv_clock_video uut (
      .clock(clock),
      .rst(rst),
      .two_to_one_mode(two_to_one_mode),
      .div_select_low_bit(lo),
      .div_select_high_bit(hi),
      .sync_decode_enable(sync_decode_enable),
      .pixel_load_strobe_in(pixel_load_strobe_in),
      .pixel_port_a(pixel_port_a),
      .pixel_port_b(pixel_port_b),
      .video_shift_clock_in(video_shift_clock_in),
      .divided_load_clock_out(divided_load_clock_out),
      .programmable_divided_clock(q),
      .gated_video_shift_clock(gated_video_shift_clock),
      .pipelined_sync_echo(pipelined_sync_echo),
      .video_out(video_out)
   );
   pcv_partner partner (
      .clock(clock),
      .divided_load_clock_out(divided_load_clock_out),
      .pixel_port_a(pixel_port_a),
      .pixel_port_b(pixel_port_b),
      .pixel_load_strobe_in(pixel_load_strobe_in)
   );
   // Pixel rate clock from the far side
   initial forever #5 clock = ~clock;
   // Compares one video word
   task automatic check_video(input pcv_video_t got, input pcv_video_t exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: video %h expected %h", $time, got, exp);
      end
   endtask
   // Compares one output bit
   task automatic check_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   // Compares a count or a period
   task automatic check_count(input longint got, input longint exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   // Sends a pair, then judges shift gate, both video words and sync echo
   task automatic pair_and_judge(input pcv_pixel_t a, input pcv_pixel_t b, input pcv_video_t exp_a,
         input pcv_video_t exp_b, input logic gate_a, input logic gate_b, input logic echo_a, input logic echo_b);
      partner.send(a, b);
      @(posedge clock);
      #1;
      check_bit(gated_video_shift_clock, gate_a);
      @(posedge clock);
      #1;
      check_bit(gated_video_shift_clock, gate_b);
      check_video(video_out, exp_a);
      check_bit(pipelined_sync_echo, echo_a);
      @(posedge clock);
      #1;
      check_video(video_out, exp_b);
      check_bit(pipelined_sync_echo, echo_b);
   endtask
   // Counts load slots over eight cycles in each mode
   task automatic scen_load_clock;
      int n;
      n = 0;
      two_to_one_mode = 1'b0;
      @(posedge clock);
      #1;
      repeat (8) begin
         @(posedge clock);
         #1;
         n += divided_load_clock_out;
      end
      check_count(n, 8);
      n = 0;
      two_to_one_mode = 1'b1;
      repeat (8) begin
         @(posedge clock);
         #1;
         n += divided_load_clock_out;
      end
      check_count(n, 4);
   endtask
   // Two halves of one load go out in turn
   task automatic scen_two_to_one;
      two_to_one_mode = 1'b1;
      sync_decode_enable = 1'b1;
      video_shift_clock_in = 1'b1;
      pair_and_judge({8'h11, 8'h22, 8'h33, 4'hb}, {8'h44, 8'h55, 8'h66, 4'h3}, {8'h11, 8'h22, 8'h33, 1'b0},
         {8'h44, 8'h55, 8'h66, 1'b0}, 1'b1, 1'b1, 1'b1, 1'b1);
   endtask
   // Only port A counts in one to one mode
   task automatic scen_one_to_one;
      two_to_one_mode = 1'b0;
      pair_and_judge({8'h12, 8'h34, 8'h56, 4'h3}, {8'h9a, 8'hbc, 8'hde, 4'h3}, {8'h12, 8'h34, 8'h56, 1'b0},
         {8'h12, 8'h34, 8'h56, 1'b0}, 1'b1, 1'b1, 1'b1, 1'b1);
      two_to_one_mode = 1'b1;
   endtask
   // Blanked half goes to blank level and stops the shift clock
   task automatic scen_blank;
      pair_and_judge({8'h77, 8'h88, 8'h99, 4'h1}, {8'h21, 8'h43, 8'h65, 4'h3}, {8'h00, 8'h00, 8'h00, 1'b0},
         {8'h21, 8'h43, 8'h65, 1'b0}, 1'b0, 1'b1, 1'b1, 1'b1);
   endtask
   // Sync inside blank shows on green when enabled
   task automatic scen_sync_enabled;
      sync_decode_enable = 1'b1;
      pair_and_judge({8'h5a, 8'h5a, 8'h5a, 4'h0}, {8'ha5, 8'ha5, 8'ha5, 4'h1}, {8'h00, 8'h00, 8'h00, 1'b1},
         {8'h00, 8'h00, 8'h00, 1'b0}, 1'b0, 1'b0, 1'b0, 1'b1);
   endtask
   // Sync is ignored when decoding is off, but still echoed
   task automatic scen_sync_disabled;
      sync_decode_enable = 1'b0;
      pair_and_judge({8'h5a, 8'h5a, 8'h5a, 4'h0}, {8'ha5, 8'ha5, 8'ha5, 4'h0}, {8'h00, 8'h00, 8'h00, 1'b0},
         {8'h00, 8'h00, 8'h00, 1'b0}, 1'b0, 1'b0, 1'b0, 1'b0);
      sync_decode_enable = 1'b1;
   endtask
   // Shift clock input low gives no shift clock
   task automatic scen_shift_off;
      video_shift_clock_in = 1'b0;
      pair_and_judge({8'h01, 8'h02, 8'h03, 4'h3}, {8'h04, 8'h05, 8'h06, 4'h3}, {8'h01, 8'h02, 8'h03, 1'b0},
         {8'h04, 8'h05, 8'h06, 1'b0}, 1'b0, 1'b0, 1'b1, 1'b1);
      video_shift_clock_in = 1'b1;
   endtask
   // Partner blanks any pixel that carries sync
   task automatic scen_sync_in_blank;
      pair_and_judge({8'hf0, 8'hf1, 8'hf2, 4'h2}, {8'h0f, 8'h1f, 8'h2f, 4'h3}, {8'h00, 8'h00, 8'h00, 1'b1},
         {8'h0f, 8'h1f, 8'h2f, 1'b0}, 1'b0, 1'b1, 1'b0, 1'b1);
   endtask
   // Prints the counts and the verdict, then ends the run
   task final_report;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Sets a ratio code and compares one output period
   task check_ratio(input logic [1:0] sel);
      @(posedge clock) #1 {hi, lo} = sel;
      repeat (70) @(posedge clock);
      @(posedge q) t = $time;
      @(posedge q) t = $time - t;
      check_count(t, 40 << sel);
   endtask
   // Hang guard
   always @(posedge clock) if (++cyc > 4000) begin errors++; final_report; end
   initial begin
      repeat (3) @(posedge clock);
      #1 rst = 0;
      scen_load_clock();
      scen_two_to_one();
      scen_one_to_one();
      scen_blank();
      scen_sync_enabled();
      scen_sync_disabled();
      scen_shift_off();
      scen_sync_in_blank();
      for (int s = 3; s >= 0; s--) check_ratio(s[1:0]);
      final_report;
   end
endmodule

/* File: verilog/pcv_defines.svh */
// Constants for the pixel clock and video control block
`ifndef PCV_DEFINES_SVH
`define PCV_DEFINES_SVH
`define PCV_DIV_SEL_4 2'h0
`define PCV_DIV_SEL_8 2'h1
`define PCV_DIV_SEL_16 2'h2
`define PCV_DIV_SEL_32 2'h3
`define PCV_HALF_4 5'h01
`define PCV_HALF_8 5'h03
`define PCV_HALF_16 5'h07
`define PCV_HALF_32 5'h0f
`define PCV_CNT_ZERO 5'h00
`define PCV_CNT_ONE 5'h01
`define PCV_PIPE_STAGES 3
`define PCV_BLANK_LEVEL 8'h00
`define PCV_SYNC_LEVEL 1'b1
`define PCV_SYNC_IDLE 1'b0
`define PCV_SYNC_N_IDLE 1'b1
`define PCV_EDGE_STAGES 2
`define PCV_IDLE_PIXEL 28'h000_0001
`define PCV_IDLE_VIDEO 25'h000_0000
`define PCV_LOAD_IDLE 1'b0
`define PCV_LOAD_ACTIVE 1'b1
`define PCV_GATE_OFF 1'b0
`endif

/* File: verilog/pcv_divider.sv */
// Pixel clock generation, pixel capture and video control path, with its divider
`include "pcv_defines.svh"

module pcv_clock_video
   import pcv_pkg::*;
#(
   parameter int PIPE_STAGES = `PCV_PIPE_STAGES
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic two_to_one_mode,
   input wire logic div_select_low_bit,
   input wire logic div_select_high_bit,
   input wire logic sync_decode_enable,
   input wire logic pixel_load_strobe_in,
   input wire pcv_pixel_t pixel_port_a,
   input wire pcv_pixel_t pixel_port_b,
   input wire logic video_shift_clock_in,
   output logic divided_load_clock_out,
   output logic programmable_divided_clock,
   output logic gated_video_shift_clock,
   output logic pipelined_sync_echo,
   output pcv_video_t video_out
);

   // ****************************************************************
   // Internal state
   // ****************************************************************

   // Which half the serialiser hands on next
   pcv_half_t half_reg;
   // Second half waiting for its turn in two to one mode
   pcv_pixel_t hold_b_reg;
   // Serialised pixel, first pipeline stage
   pcv_pixel_t ser_reg;
   // Middle pipeline stages between serialiser and output stage
   pcv_pixel_t delay_reg [PIPE_STAGES-`PCV_EDGE_STAGES];
   // Pixel about to enter the output stage
   pcv_pixel_t pre_out;
   // Sync is to be shown on the green channel
   logic sync_on;

   // ****************************************************************
   // Load clock
   // ****************************************************************

   // One-cycle load slots at the pixel rate over the mux factor
   // In one to one mode every cycle is a slot, so the output stands high
   always_ff @(posedge clock) begin
      if (rst) begin
         divided_load_clock_out <= `PCV_LOAD_IDLE;
      end else if (two_to_one_mode) begin
         divided_load_clock_out <= ~divided_load_clock_out;
      end else begin
         divided_load_clock_out <= `PCV_LOAD_ACTIVE;
      end
   end

   // ****************************************************************
   // Programmable divided clock
   // ****************************************************************

   // Divider runs from the same pixel clock, output straight from its flop
   pcv_divider u_divider (
      .clock(clock),
      .rst(rst),
      .div_select_low_bit(div_select_low_bit),
      .div_select_high_bit(div_select_high_bit),
      .programmable_divided_clock(programmable_divided_clock)
   );

   // ****************************************************************
   // Pixel capture and serialiser
   // ****************************************************************

   // Captures both port halves on a load strobe, then hands on A and, in two to one mode, B in turn
   // A strobe while B is still due is refused: the partner only loads every other cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         ser_reg <= `PCV_IDLE_PIXEL;
         hold_b_reg <= `PCV_IDLE_PIXEL;
         half_reg <= PCV_PORT_A;
      end else begin
         case (half_reg)
            PCV_PORT_A: begin
               if (pixel_load_strobe_in) begin
                  ser_reg <= pixel_port_a;
                  hold_b_reg <= pixel_port_b;
                  half_reg <= two_to_one_mode ? PCV_PORT_B : PCV_PORT_A;
               end
            end
            PCV_PORT_B: begin
               ser_reg <= hold_b_reg;
               half_reg <= PCV_PORT_A;
            end
            default: begin
               half_reg <= PCV_PORT_A;
            end
         endcase
      end
   end

   // ****************************************************************
   // Pipeline delay line
   // ****************************************************************

   // Middle stages keep sync echo and video in the same cycle
   genvar g;
   generate
      for (g = 0; g < PIPE_STAGES - `PCV_EDGE_STAGES; g++) begin : g_delay
         if (g == 0) begin : g_first
            always_ff @(posedge clock) begin
               if (rst) begin
                  delay_reg[g] <= `PCV_IDLE_PIXEL;
               end else begin
                  delay_reg[g] <= ser_reg;
               end
            end
         end else begin : g_next
            always_ff @(posedge clock) begin
               if (rst) begin
                  delay_reg[g] <= `PCV_IDLE_PIXEL;
               end else begin
                  delay_reg[g] <= delay_reg[g-1];
               end
            end
         end
      end
   endgenerate

   // Last middle stage feeds the output stage
   assign pre_out = delay_reg[PIPE_STAGES-`PCV_EDGE_STAGES-1];

   // ****************************************************************
   // Video control
   // ****************************************************************

   // Sync is active low and only counts when decoding is enabled
   assign sync_on = ~pre_out.sync_n & sync_decode_enable;

   // Output stage: blank forces the blanking level on every channel
   always_ff @(posedge clock) begin
      if (rst) begin
         video_out <= `PCV_IDLE_VIDEO;
      end else if (!pre_out.blank_n) begin
         video_out.red <= `PCV_BLANK_LEVEL;
         video_out.green_current_output <= `PCV_BLANK_LEVEL;
         video_out.blue <= `PCV_BLANK_LEVEL;
         video_out.green_sync <= sync_on ? `PCV_SYNC_LEVEL : `PCV_SYNC_IDLE;
      end else begin
         video_out.red <= pre_out.red;
         video_out.green_current_output <= pre_out.green;
         video_out.blue <= pre_out.blue;
         video_out.green_sync <= sync_on ? `PCV_SYNC_LEVEL : `PCV_SYNC_IDLE;
      end
   end

   // Sync echo leaves the output stage together with its pixel
   always_ff @(posedge clock) begin
      if (rst) begin
         pipelined_sync_echo <= `PCV_SYNC_N_IDLE;
      end else begin
         pipelined_sync_echo <= pre_out.sync_n;
      end
   end

   // Shift clock is stopped while the serialised pixel is blanked
   always_ff @(posedge clock) begin
      if (rst) begin
         gated_video_shift_clock <= `PCV_GATE_OFF;
      end else begin
         gated_video_shift_clock <= video_shift_clock_in & ser_reg.blank_n;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   // Load clock toggles every cycle in two to one mode
   property p_load_toggle_two;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && $past(two_to_one_mode)) |-> (divided_load_clock_out != $past(divided_load_clock_out));
   endproperty
   a_load_toggle_two: assert property (p_load_toggle_two) else $error("load clock did not toggle");

   // Load clock stands high in one to one mode
   property p_load_steady_one;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && !$past(two_to_one_mode)) |-> divided_load_clock_out;
   endproperty
   a_load_steady_one: assert property (p_load_steady_one) else $error("load clock low in one to one");

   // Blanked pixel leaves at the blanking level
   property p_blank_level;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && !$past(pre_out.blank_n)) |-> (video_out.red == `PCV_BLANK_LEVEL &&
            video_out.green_current_output == `PCV_BLANK_LEVEL && video_out.blue == `PCV_BLANK_LEVEL);
   endproperty
   a_blank_level: assert property (p_blank_level) else $error("blanked pixel not at blank level");

   // Enabled sync drives green to the sync level
   property p_sync_green;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && $past(!pre_out.sync_n && sync_decode_enable)) |-> (video_out.green_sync == `PCV_SYNC_LEVEL);
   endproperty
   a_sync_green: assert property (p_sync_green) else $error("sync not shown on green");

   // Sync is ignored while decoding is disabled
   property p_sync_ignored;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && !$past(sync_decode_enable)) |-> (video_out.green_sync == `PCV_SYNC_IDLE);
   endproperty
   a_sync_ignored: assert property (p_sync_ignored) else $error("sync shown while disabled");

   // Sync echo matches the pixel leaving the output stage
   property p_sync_echo;
      @(posedge clock) disable iff (rst)
         !$past(rst) |-> (pipelined_sync_echo == $past(pre_out.sync_n));
   endproperty
   a_sync_echo: assert property (p_sync_echo) else $error("sync echo out of step");

   // No shift clock while the serialised pixel is blanked
   property p_shift_gated;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && !$past(ser_reg.blank_n)) |-> !gated_video_shift_clock;
   endproperty
   a_shift_gated: assert property (p_shift_gated) else $error("shift clock ran during blank");

   // Second half always goes out in the cycle after the first
   property p_half_b_follows;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && $past(half_reg == PCV_PORT_B)) |-> (half_reg == PCV_PORT_A);
   endproperty
   a_half_b_follows: assert property (p_half_b_follows) else $error("second half not handed on");

   // Main scenarios reached
   c_two_to_one_load: cover property (@(posedge clock) disable iff (rst) two_to_one_mode && pixel_load_strobe_in);
   c_blank_out: cover property (@(posedge clock) disable iff (rst) !pre_out.blank_n);
   c_sync_green: cover property (@(posedge clock) disable iff (rst) video_out.green_sync);
   c_shift_stopped: cover property (@(posedge clock) disable iff (rst) video_shift_clock_in && !ser_reg.blank_n);

endmodule

// ****************************************************************
// Programmable clock divider producing divide by 4, 8, 16 or 32
// ****************************************************************
module pcv_divider
   import pcv_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic div_select_low_bit,
   input wire logic div_select_high_bit,
   output logic programmable_divided_clock
);
   logic [4:0] cnt_reg;
   logic [4:0] half_limit;

   // Decode of the two select bits into half period minus one
   always_comb begin
      case ({div_select_high_bit, div_select_low_bit})
         `PCV_DIV_SEL_4: half_limit = `PCV_HALF_4;
         `PCV_DIV_SEL_8: half_limit = `PCV_HALF_8;
         `PCV_DIV_SEL_16: half_limit = `PCV_HALF_16;
         default: half_limit = `PCV_HALF_32;
      endcase
   end

   // Half period counter toggles the output
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= `PCV_CNT_ZERO;
         programmable_divided_clock <= 1'b0;
      end else if (cnt_reg >= half_limit) begin
         cnt_reg <= `PCV_CNT_ZERO;
         programmable_divided_clock <= ~programmable_divided_clock;
      end else begin
         cnt_reg <= cnt_reg + `PCV_CNT_ONE;
      end
   end

   // Half period is never shorter than two cycles
   property p_div_min_half;
      @(posedge clock) disable iff (rst)
         (!$past(rst) && $changed(programmable_divided_clock)) |=> $stable(programmable_divided_clock);
   endproperty
   a_div_min_half: assert property (p_div_min_half) else $error("divided clock half period too short");
endmodule

/* File: verilog/pcv_pkg.sv */
// Types shared by the pixel clock and video control block
package pcv_pkg;
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic palette_select_bit0;
      logic palette_select_bit1;
      logic blank_n;
      logic sync_n;
   } pcv_pixel_t;
   typedef enum logic [1:0] {
      PCV_PORT_A = 2'b01,
      PCV_PORT_B = 2'b10
   } pcv_half_t;
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green_current_output;
      logic [7:0] blue;
      logic green_sync;
   } pcv_video_t;
endpackage
